// ---- rtl/sqd_pkg.sv ----
/*
  Shared constants of the squib deployment arming control: timebase,
  durations, serial frame layout and driver-port mode codes.
  Assumes a single 50 MHz system clock; all durations become cycle counts.
*/
package sqd_pkg;

  // ----------------------------------------------------------------
  // Timebase and durations
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned FIRE_US = 2000;   // Fire duration
  localparam int unsigned PST_US = 1000;    // Pulse stretch window
  localparam int unsigned GLITCH_US = 10;   // Deglitch time of fire enable
  localparam int unsigned DIAG_US = 100;    // Switch diagnostic on-time
  localparam int unsigned FIRE_CYC = FIRE_US * CLK_MHZ;
  localparam int unsigned PST_CYC = PST_US * CLK_MHZ;
  localparam int unsigned GLITCH_CYC = GLITCH_US * CLK_MHZ;
  localparam int unsigned DIAG_CYC = DIAG_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned NCH = 8;
  localparam int unsigned DRV_BITS = 16;
  localparam int unsigned ARM_BITS = 8;
  localparam int unsigned MODE_MSB = 15;
  localparam int unsigned MODE_LSB = 14;
  localparam int unsigned DIAG_SIDE_BIT = 8;  // 1 high side, 0 low side
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_CMD = 2'h1;
  localparam logic [1:0] MODE_DIAG = 2'h2;
  localparam logic [1:0] MODE_MON = 2'h3;
  localparam logic [15:0] RESP_FAULT = 16'hE000;
  localparam logic [4:0] DRV_CNT_MAX = 5'h1F;

endpackage

// ---- rtl/sqd_deploy_ctrl.sv ----
/*
  Deployment and arming control of an eight-loop squib driver: driver
  command serial port, 8-bit arming serial port, per-loop pulse stretch
  timers, fire enable deglitch and switch drive.
  Assumes serial pins and resets arrive asynchronously and serial clocks are
  slow against mclk_i; chip selects are active low; analog parts live outside.
*/
// How it works
// - Data outputs released while chip select negated
// - Shift responses out MSB first
// - Set success flag when deployment completes
// - Switches on only for fire or diagnostic
// - One pulse stretch timer pair per loop
// - Arming port moves whole bytes, separate port
// - Arm select release latches bits, starts timers
// - Fire needs enable and cross-started timer
// - Deployment runs full time, only reset stops
// - Deploy-enable starts timer at frame end
// - Deploy re-enable restarts; disable stops own timer
// - Arm-enable starts timer at frame end
// - Arm re-enable restarts; disable stops own timer
// - Register/diagnostic frames faulted during deployment
// - Command skips deploying loops; monitor returns status
// - Answer goes out in following transfer
// - Arming commands ignored during any deployment
// - Enable gates turn-on, never aborts fire
// - Diagnostic runs with enable low, switches off
// - Enable low blocks deploy start, not arming
// - Register answer echoes previous deploy bits
// - Enable changes never touch running timers
// - Enable pin deglitched by filter time
// - Arming answer: status byte then received bits
// - External reset ignored during deployment
`timescale 1ns/1ps
`default_nettype none
module sqd_deploy_ctrl #(
  parameter int unsigned FIRE_CYC = sqd_pkg::FIRE_CYC,
  parameter int unsigned PST_CYC = sqd_pkg::PST_CYC,
  parameter int unsigned DIAG_CYC = sqd_pkg::DIAG_CYC,
  parameter int unsigned GLITCH_CYC = sqd_pkg::GLITCH_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic external_reset_n_i,
  input wire logic fire_enable_pin_i,
  input wire logic drv_cs_n_i,
  input wire logic drv_sclk_i,
  input wire logic drv_mosi_i,
  output logic drv_miso_o,
  output logic drv_miso_oe_o,
  input wire logic arm_cs_n_i,
  input wire logic arm_sclk_i,
  input wire logic arm_mosi_i,
  output logic arm_miso_o,
  output logic arm_miso_oe_o,
  output logic [7:0] loop_high_side_switch_o,
  output logic [7:0] loop_low_side_switch_o,
  output logic [7:0] deploying_o,
  output logic [7:0] deploy_success_o,
  output logic fire_enable_filt_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage 1 feeds stage 2 only; stage 3 exists for edge detection
  logic [7:0] s1_r, s2_r, s3_r;
  always_ff @(posedge mclk_i) begin
    s1_r <= {external_reset_n_i, fire_enable_pin_i, drv_cs_n_i, drv_sclk_i,
             drv_mosi_i, arm_cs_n_i, arm_sclk_i, arm_mosi_i};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  wire ext_rst_n_s = s2_r[7];
  wire en_s = s2_r[6];
  wire dcs_n = s2_r[5];
  wire d_mosi = s2_r[3];
  wire acs_n = s2_r[2];
  wire a_mosi = s2_r[0];
  wire d_sel = ~s3_r[5] & s2_r[5] ? 1'b0 : ~dcs_n;
  wire d_start = s3_r[5] & ~s2_r[5];
  wire d_end = ~s3_r[5] & s2_r[5];
  wire d_rise = d_sel & ~s3_r[4] & s2_r[4];
  wire d_fall = d_sel & s3_r[4] & ~s2_r[4];
  wire a_sel = ~acs_n;
  wire a_start = s3_r[2] & ~s2_r[2];
  wire a_end = ~s3_r[2] & s2_r[2];
  wire a_rise = a_sel & ~s3_r[1] & s2_r[1];
  wire a_fall = a_sel & s3_r[1] & ~s2_r[1];

  // ----------------------------------------------------------------
  // Reset handling
  // ----------------------------------------------------------------
  logic [7:0] dep_r;
  wire any_dep = |dep_r;
  // External reset only acts once no loop is firing
  wire irst = rst_i | (~ext_rst_n_s & ~any_dep);

  // ----------------------------------------------------------------
  // Fire enable deglitch
  // ----------------------------------------------------------------
  logic en_f_r;
  logic [31:0] gl_cnt_r;
  wire gl_done = gl_cnt_r == 32'(GLITCH_CYC - 1);
  // Level must differ for the whole filter time before it is taken
  always_ff @(posedge mclk_i) begin
    if (irst) begin
      en_f_r <= 1'b0;
      gl_cnt_r <= '0;
    end else if (en_s == en_f_r) begin
      gl_cnt_r <= '0;
    end else if (gl_done) begin
      en_f_r <= en_s;
      gl_cnt_r <= '0;
    end else begin
      gl_cnt_r <= gl_cnt_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Driver command port
  // ----------------------------------------------------------------
  logic [15:0] d_rx_r, d_tx_r, d_resp_r;
  logic [4:0] d_cnt_r;
  logic d_miso_r, d_oe_r;
  logic [7:0] echo_r, succ_r;
  wire [1:0] d_mode = d_rx_r[sqd_pkg::MODE_MSB:sqd_pkg::MODE_LSB];
  wire d_ok = d_end & (d_cnt_r == 5'(sqd_pkg::DRV_BITS));
  // Register and diagnostic frames are dropped while a loop fires
  wire d_drop = any_dep & ((d_mode == sqd_pkg::MODE_REG) | (d_mode == sqd_pkg::MODE_DIAG));
  wire cmd_ok = d_ok & (d_mode == sqd_pkg::MODE_CMD);
  wire diag_ok = d_ok & ~d_drop & (d_mode == sqd_pkg::MODE_DIAG);
  wire mon_ok = d_ok & (d_mode == sqd_pkg::MODE_MON);
  wire [15:0] resp_nxt =
    (~d_ok | d_drop) ? sqd_pkg::RESP_FAULT :
    (d_mode == sqd_pkg::MODE_CMD) ? {sqd_pkg::MODE_CMD, 6'h00, d_rx_r[7:0]} :
    (d_mode == sqd_pkg::MODE_MON) ? {sqd_pkg::MODE_MON, 6'h00, succ_r} :
    (d_mode == sqd_pkg::MODE_DIAG) ? {sqd_pkg::MODE_DIAG, 6'h00, dep_r} :
    {sqd_pkg::MODE_REG, 6'h00, echo_r};

  // Answer built at frame end goes out in the next frame
  always_ff @(posedge mclk_i) begin
    if (irst) begin
      d_resp_r <= sqd_pkg::RESP_FAULT;
      echo_r <= '0;
    end else if (d_end) begin
      d_resp_r <= resp_nxt;
      if (cmd_ok) begin
        echo_r <= d_rx_r[7:0];  // Echoed whatever the enable level
      end
    end
  end

  // Shift: sample on rising, drive next bit on falling, MSB first
  always_ff @(posedge mclk_i) begin
    if (irst) begin
      d_cnt_r <= '0;
      d_rx_r <= '0;
      d_tx_r <= '0;
      d_miso_r <= 1'b0;
      d_oe_r <= 1'b0;
    end else begin
      d_oe_r <= d_sel;  // Driven only while selected
      if (d_start) begin
        d_cnt_r <= '0;
        d_tx_r <= d_resp_r;
        d_miso_r <= d_resp_r[15];
      end else if (d_rise) begin
        d_rx_r <= {d_rx_r[14:0], d_mosi};
        d_tx_r <= {d_tx_r[14:0], 1'b0};
        if (d_cnt_r != sqd_pkg::DRV_CNT_MAX) begin
          d_cnt_r <= d_cnt_r + 5'h1;
        end
      end else if (d_fall) begin
        d_miso_r <= d_tx_r[15];
      end
    end
  end

  // ----------------------------------------------------------------
  // Arming port
  // ----------------------------------------------------------------
  logic [7:0] a_sr_r;
  wire [7:0] a_stat;  // One driver per loop, so a net rather than a variable
  logic [2:0] a_cnt_r;
  logic a_byte_r, a_miso_r, a_oe_r;
  // Whole bytes only, ignored while any loop fires
  wire arm_ok = a_end & a_byte_r & (a_cnt_r == 3'h0) & ~any_dep;

  // Status byte goes out first, then received bits follow through
  always_ff @(posedge mclk_i) begin
    if (irst) begin
      a_sr_r <= '0;
      a_cnt_r <= '0;
      a_byte_r <= 1'b0;
      a_miso_r <= 1'b0;
      a_oe_r <= 1'b0;
    end else begin
      a_oe_r <= a_sel;
      if (a_start) begin
        a_sr_r <= a_stat;
        a_miso_r <= a_stat[7];
        a_cnt_r <= '0;
        a_byte_r <= 1'b0;
      end else if (a_rise) begin
        a_sr_r <= {a_sr_r[6:0], a_mosi};
        a_cnt_r <= a_cnt_r + 3'h1;
        if (a_cnt_r == 3'(sqd_pkg::ARM_BITS - 1)) begin
          a_byte_r <= 1'b1;
        end
      end else if (a_fall) begin
        a_miso_r <= a_sr_r[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-loop timers and switch drive
  // ----------------------------------------------------------------
  logic [7:0] hs_r, ls_r;
  genvar i;
  for (i = 0; i < sqd_pkg::NCH; i++) begin : g_ch
    logic [31:0] at_r, dt_r, fc_r, dg_r;
    logic side_r;
    wire at_act = at_r != 32'h0;
    wire dt_act = dt_r != 32'h0;
    // Command mode never touches a loop that is firing
    wire d_on = cmd_ok & d_rx_r[i] & ~dep_r[i];
    wire d_off = cmd_ok & ~d_rx_r[i] & ~dep_r[i];
    wire a_on = arm_ok & a_sr_r[i];  // Latched at select release
    wire a_off = arm_ok & ~a_sr_r[i];
    // Cross-started window plus filtered enable
    wire go = en_f_r & ~dep_r[i] & ((d_on & at_act) | (a_on & dt_act));
    wire fin = fc_r == 32'h1;
    assign a_stat[i] = at_act;

    // Deploy-started timer; load gated by enable, run not
    always_ff @(posedge mclk_i) begin
      if (irst) begin
        dt_r <= '0;
      end else if (d_on & en_f_r) begin
        dt_r <= 32'(PST_CYC);
      end else if (d_off) begin
        dt_r <= '0;
      end else if (dt_act) begin
        dt_r <= dt_r - 32'h1;
      end
    end

    // Arm-started timer, independent of enable
    always_ff @(posedge mclk_i) begin
      if (irst) begin
        at_r <= '0;
      end else if (a_on) begin
        at_r <= 32'(PST_CYC);
      end else if (a_off) begin
        at_r <= '0;
      end else if (at_act) begin
        at_r <= at_r - 32'h1;
      end
    end

    // Fire counter: only the supply reset can stop it
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        fc_r <= '0;
        dep_r[i] <= 1'b0;
      end else if (go) begin
        fc_r <= 32'(FIRE_CYC);
        dep_r[i] <= 1'b1;
      end else if (dep_r[i]) begin
        fc_r <= fc_r - 32'h1;
        dep_r[i] <= ~fin;
      end
    end

    // Success is sticky; a monitor read clears it, completion wins
    always_ff @(posedge mclk_i) begin
      if (irst) begin
        succ_r[i] <= 1'b0;
      end else if (dep_r[i] & fin) begin
        succ_r[i] <= 1'b1;
      end else if (mon_ok) begin
        succ_r[i] <= 1'b0;
      end
    end

    // Diagnostic runs its time even with enable low
    always_ff @(posedge mclk_i) begin
      if (irst) begin
        dg_r <= '0;
        side_r <= 1'b0;
      end else if (diag_ok & d_rx_r[i]) begin
        dg_r <= 32'(DIAG_CYC);
        side_r <= d_rx_r[sqd_pkg::DIAG_SIDE_BIT];
      end else if (dg_r != 32'h0) begin
        dg_r <= dg_r - 32'h1;
      end
    end

    // Switches: fire, or enabled diagnostic; off otherwise
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        hs_r[i] <= 1'b0;
        ls_r[i] <= 1'b0;
      end else begin
        hs_r[i] <= dep_r[i] | (en_f_r & (dg_r != 32'h0) & side_r);
        ls_r[i] <= dep_r[i] | (en_f_r & (dg_r != 32'h0) & ~side_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign drv_miso_o = d_miso_r;
  assign drv_miso_oe_o = d_oe_r;
  assign arm_miso_o = a_miso_r;
  assign arm_miso_oe_o = a_oe_r;
  assign loop_high_side_switch_o = hs_r;
  assign loop_low_side_switch_o = ls_r;
  assign deploying_o = dep_r;
  assign deploy_success_o = succ_r;
  assign fire_enable_filt_o = en_f_r;

endmodule
`default_nettype wire

// ---- testbench/sqd_spi_master.sv ----
/*
  Serial master model for the driver and arming ports.
  Assumes every call starts just after a falling mclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sqd_spi_master #(
  parameter int W = 16
) (
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic oe_i
);
  // ----------
  // Frame
  // ----------
  // Released line reads Z, so a late enable fails the compare
  wire logic line_w = oe_i ? miso_i : 1'bz;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Clock idles low; 80 ns halves keep every change on a mclk edge
  task automatic xfer(input logic [W-1:0] tx, input int nb, output logic [W-1:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    #160;
    for (int i = 0; i < nb; i++) begin
      mosi_o = tx[W-1-i];
      #80 sclk_o = 1'b1;
      rx = {rx[W-2:0], line_w};
      #80 sclk_o = 1'b0;
    end
    #80 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Floating line after release
    #240;
  endtask
endmodule
`default_nettype wire

// ---- testbench/sqd_deploy_ctrl_assertions.sv ----
/*
  Port checker of the deployment control.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module sqd_deploy_ctrl_chk #(
  parameter int unsigned FIRE_CYC = sqd_pkg::FIRE_CYC,
  parameter int unsigned PST_CYC = sqd_pkg::PST_CYC,
  parameter int unsigned DIAG_CYC = sqd_pkg::DIAG_CYC,
  parameter int unsigned GLITCH_CYC = sqd_pkg::GLITCH_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic external_reset_n_i,
  input wire logic fire_enable_pin_i,
  input wire logic drv_cs_n_i,
  input wire logic drv_sclk_i,
  input wire logic drv_mosi_i,
  input wire logic drv_miso_o,
  input wire logic drv_miso_oe_o,
  input wire logic arm_cs_n_i,
  input wire logic arm_sclk_i,
  input wire logic arm_mosi_i,
  input wire logic arm_miso_o,
  input wire logic arm_miso_oe_o,
  input wire logic [7:0] loop_high_side_switch_o,
  input wire logic [7:0] loop_low_side_switch_o,
  input wire logic [7:0] deploying_o,
  input wire logic [7:0] deploy_success_o,
  input wire logic fire_enable_filt_o
);
  // ----------
  // Helpers
  // ----------
  localparam int GL = GLITCH_CYC;
  logic [7:0] dep_r;
  logic pin_r;
  logic [10:0] stab_r;
  logic [31:0] on_r;
  // Stability count saturates so a long quiet pin never wraps
  wire logic [10:0] stab_nxt = (rst_i || fire_enable_pin_i != pin_r) ? 11'h000 : stab_r + {10'h000, stab_r != 11'h7FF};
  wire logic both_w = loop_high_side_switch_o[0] & loop_low_side_switch_o[0];
  wire logic [31:0] on_nxt = both_w ? on_r + 32'h1 : 32'h0;
  wire logic [7:0] new_dep = deploying_o & ~dep_r;
  wire logic [7:0] both_v = loop_high_side_switch_o & loop_low_side_switch_o;
  always_ff @(posedge mclk_i) begin
    dep_r <= deploying_o;
    pin_r <= fire_enable_pin_i;
    stab_r <= stab_nxt;
    on_r <= on_nxt;
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_drv_hiz; drv_cs_n_i [*6] |-> !drv_miso_oe_o; endproperty
  a_drv_hiz: assert property (p_drv_hiz) else $error("drv out not released");
  property p_arm_hiz; arm_cs_n_i [*6] |-> !arm_miso_oe_o; endproperty
  a_arm_hiz: assert property (p_arm_hiz) else $error("arm out not released");
  property p_fire_sw; new_dep != 8'h00 |=> (both_v & dep_r) == dep_r; endproperty
  a_fire_sw: assert property (p_fire_sw) else $error("fire without switches");
  property p_both_fire; (both_v & ~(deploying_o | dep_r)) == 8'h00; endproperty
  a_both_fire: assert property (p_both_fire) else $error("both switches without fire");
  property p_fire_len; $fell(both_w) |-> on_r + 1 >= FIRE_CYC && on_r <= FIRE_CYC + 1; endproperty
  a_fire_len: assert property (p_fire_len) else $error("fire length wrong");
  property p_ext_rst; deploying_o[0] && !external_reset_n_i && on_r + 8 < FIRE_CYC |=> deploying_o[0]; endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("pin reset stopped fire");
  property p_fire_en; new_dep != 8'h00 |-> $past(fire_enable_filt_o) || $past(fire_enable_filt_o, 2); endproperty
  a_fire_en: assert property (p_fire_en) else $error("fire with enable low");
  property p_glitch_min; $changed(fire_enable_filt_o) |-> stab_r >= GL - 4; endproperty
  a_glitch_min: assert property (p_glitch_min) else $error("enable glitch passed");
  property p_glitch_follow; stab_r == GL + 8 |-> fire_enable_filt_o == pin_r; endproperty
  a_glitch_follow: assert property (p_glitch_follow) else $error("enable not followed");
  c_fire: cover property (new_dep != 8'h00);
  c_en: cover property ($rose(fire_enable_filt_o));
  c_arm: cover property ($rose(arm_miso_oe_o));
endmodule
bind sqd_deploy_ctrl sqd_deploy_ctrl_chk #(.FIRE_CYC(FIRE_CYC), .PST_CYC(PST_CYC), .DIAG_CYC(DIAG_CYC),
  .GLITCH_CYC(GLITCH_CYC)) u_chk (
  .mclk_i, .rst_i, .external_reset_n_i, .fire_enable_pin_i, .drv_cs_n_i, .drv_sclk_i, .drv_mosi_i,
  .drv_miso_o, .drv_miso_oe_o, .arm_cs_n_i, .arm_sclk_i, .arm_mosi_i, .arm_miso_o, .arm_miso_oe_o,
  .loop_high_side_switch_o, .loop_low_side_switch_o, .deploying_o, .deploy_success_o, .fire_enable_filt_o);
`default_nettype wire

// ---- testbench/squib_deploy_arming_control_tb.sv ----
/*
  Self-checking bench of the squib deployment control.
  Assumes the master model paces frames at the 160 ns link period.
*/
`timescale 1ns/1ps
`default_nettype none
module squib_deploy_arming_control_tb;
  // ----------
  // Setup
  // ----------
  localparam int unsigned FIRE_CYC = 1000;
  // Enable low: frame sent, answer to the frame before
  localparam logic [15:0] ROWS [7][2] = '{
    '{16'h4000, 16'hE000},
    '{16'h0000, 16'h4000},
    '{16'h40A5, 16'h0000},
    '{16'hC000, 16'h40A5},
    '{16'h8001, 16'hC000},
    '{16'h0000, 16'h8000},
    '{16'h4000, 16'h00A5}};
  logic mclk = 1'b0;
  logic rst, ext_rst_n, en_pin, watch, en_filt;
  logic drv_cs_n, drv_sclk, drv_mosi, drv_miso, drv_oe;
  logic arm_cs_n, arm_sclk, arm_mosi, arm_miso, arm_oe;
  logic [7:0] hs, ls, dep, succ, r8;
  logic [15:0] r16;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  sqd_deploy_ctrl #(.FIRE_CYC(FIRE_CYC), .PST_CYC(400), .DIAG_CYC(50)) u_sqd_deploy_ctrl (
    .mclk_i(mclk), .rst_i(rst), .external_reset_n_i(ext_rst_n), .fire_enable_pin_i(en_pin),
    .drv_cs_n_i(drv_cs_n), .drv_sclk_i(drv_sclk), .drv_mosi_i(drv_mosi), .drv_miso_o(drv_miso),
    .drv_miso_oe_o(drv_oe), .arm_cs_n_i(arm_cs_n), .arm_sclk_i(arm_sclk), .arm_mosi_i(arm_mosi),
    .arm_miso_o(arm_miso), .arm_miso_oe_o(arm_oe), .loop_high_side_switch_o(hs),
    .loop_low_side_switch_o(ls), .deploying_o(dep), .deploy_success_o(succ), .fire_enable_filt_o(en_filt));
  sqd_spi_master #(.W(16)) u_sqd_spi_master_drv (.cs_n_o(drv_cs_n), .sclk_o(drv_sclk),
    .mosi_o(drv_mosi), .miso_i(drv_miso), .oe_i(drv_oe));
  sqd_spi_master #(.W(8)) u_sqd_spi_master_arm (.cs_n_o(arm_cs_n), .sclk_o(arm_sclk),
    .mosi_o(arm_mosi), .miso_i(arm_miso), .oe_i(arm_oe));
  // ----------
  // Tasks
  // ----------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic drv(input logic [15:0] w, input logic [15:0] exp);
    u_sqd_spi_master_drv.xfer(w, 16, r16);
    check(r16, exp);
  endtask
  task automatic arm(input logic [7:0] w, input logic [7:0] exp);
    u_sqd_spi_master_arm.xfer(w, 8, r8);
    check({8'h00, r8}, {8'h00, exp});
  endtask
  // Switch watch while enable is low, plus the hang limit
  always @(negedge mclk) begin
    cyc++;
    if (watch && (hs | ls) !== 8'h00) begin
      mismatches++;
      $display("MISMATCH t=%0t switch on", $time);
    end
    if (cyc == 12000) begin
      mismatches++;
      $display("MISMATCH t=%0t timeout", $time);
      wrap_up();
    end
  end
  // ----------
  // Sequence
  // ----------
  initial begin
    rst = 1'b1;
    ext_rst_n = 1'b1;
    en_pin = 1'b0;
    watch = 1'b1;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (ROWS[i]) drv(ROWS[i][0], ROWS[i][1]);
    // Short frame is dropped, next answer faulted
    u_sqd_spi_master_drv.xfer(16'h4000, 15, r16);
    drv(16'h0000, 16'hE000);
    // Arming timer starts with enable low and stops on disable
    arm(8'h01, 8'h00);
    arm(8'h00, 8'h01);
    arm(8'h00, 8'h00);
    // Pulse shorter than the filter is dropped
    en_pin = 1'b1;
    repeat (100) @(negedge mclk);
    en_pin = 1'b0;
    repeat (600) @(negedge mclk);
    check({15'h0000, en_filt}, 16'h0000);
    watch = 1'b0;
    en_pin = 1'b1;
    repeat (520) @(negedge mclk);
    check({15'h0000, en_filt}, 16'h0001);
    // High-side diagnostic on loop 0 with enable high, then it times out
    drv(16'h8101, 16'h0000);
    check({hs, ls}, 16'h0100);
    repeat (50) @(negedge mclk);
    check({hs, ls}, 16'h0000);
    // Arm then deploy loop 0
    arm(8'h01, 8'h00);
    drv(16'h4001, 16'h8000);
    for (int i = 0; i < 20 && dep[0] !== 1'b1; i++) @(negedge mclk);
    check({8'h00, dep}, 16'h0001);
    // Enable drop, pin reset and odd frames leave the fire running
    en_pin = 1'b0;
    ext_rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    ext_rst_n = 1'b1;
    drv(16'h0000, 16'h4001);
    drv(16'h4002, 16'hE000);
    // Arming loop 1 would fire it against its deploy timer if not ignored
    arm(8'h02, 8'h00);
    drv(16'h8001, 16'h4002);
    drv(16'hC000, 16'hE000);
    check({8'h00, dep}, 16'h0001);
    for (int i = 0; i < 1200 && dep !== 8'h00; i++) @(negedge mclk);
    check({8'h00, succ}, 16'h0001);
    drv(16'hC000, 16'hC000);
    drv(16'h4000, 16'hC001);
    check({8'h00, succ}, 16'h0000);
    // Pin reset with no loop firing clears timers and the pending answer
    arm(8'h01, 8'h00);
    ext_rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    ext_rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    arm(8'h00, 8'h00);
    drv(16'h4000, 16'hE000);
    wrap_up();
  end
endmodule
`default_nettype wire
